// *** pkg/bme_regs.vh ***
`ifndef BME_REGS_VH
`define BME_REGS_VH
// Opcode patterns
`define BME_LOOP_MASK 16'hfff8
`define BME_LOOP_CODE 16'h0008
`define BME_CMP_MASK 16'hff80
`define BME_CMP_CODE 16'h8f80
`define BME_CMP_NE_BIT 6
`define BME_QJ_MASK 16'hfff0
`define BME_QJ_CODE 16'h56c0
`define BME_MAP_CODE 16'h563f
`define BME_OBJ_CODE 16'h5636
// Cycle counts
`define BME_CYC_TAKEN 3'h4
`define BME_CYC_FALL 3'h2
`define BME_CYC_QUICK 3'h4
`define BME_CYC_MODE 3'h5
// Reset values of mode bits
`define BME_OBJ_RESET 1'b0
`define BME_MAP_RESET 1'b1
// Fall-through step
`define BME_PC_STEP 22'h000002
// Block placement limits
`define BME_BLK_TOP 11'h3ff
`endif

// *** rtl/bme_exec.v ***
// Local design decisions: the address map and the plain strobed port.
`include "bme_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module bme_exec
(
    input wire CLK,
    input wire ARST_N,
    input wire INSN_VALID,
    input wire [15:0] INSN_WORD,
    input wire [15:0] OFFSET_WORD,
    input wire [21:0] PC_IN,
    input wire RPT_PENDING,
    input wire FLAG_Z,
    input wire FLAG_N,
    input wire FLAG_C,
    input wire FLAG_V,
    input wire FLAG_TC,
    input wire BIO_PIN,
    input wire [127:0] AUX_LOW_ALL,
    input wire [10:0] PROG_ADDR,
    output reg BUSY,
    output reg DONE,
    output reg BRANCH_TAKEN,
    output reg [21:0] PC_NEXT,
    output reg AUX_WE,
    output reg [2:0] AUX_SEL,
    output reg [15:0] AUX_WDATA,
    output reg V_CLEAR,
    output reg RPT_CLEAR,
    output reg FLUSH,
    output reg ILLEGAL,
    output reg OBJECT_MODE,
    output reg BLOCK_MAP,
    output reg PROG_HITS_ONE
);

// ----------------------------------------
// Reset synchroniser
// ----------------------------------------
reg rst_meta_r;
reg rst_sync_r;

// Two-stage release of the asynchronous reset
always @(posedge CLK or negedge ARST_N)
begin
    if (!ARST_N)
    begin
        rst_meta_r <= 1'b0;
        rst_sync_r <= 1'b0;
    end
    else
    begin
        rst_meta_r <= 1'b1;
        rst_sync_r <= rst_meta_r;
    end
end

wire rst_n = rst_sync_r;

// ----------------------------------------
// Input pin synchroniser
// ----------------------------------------
reg bio_meta_r;
reg bio_sync_r;

// Pin comes from outside the clock domain
always @(posedge CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        bio_meta_r <= 1'b1;
        bio_sync_r <= 1'b1;
    end
    else
    begin
        bio_meta_r <= BIO_PIN;
        bio_sync_r <= bio_meta_r;
    end
end

// ----------------------------------------
// Functions
// ----------------------------------------
// Condition code evaluation
function test_code_field_true;
    input [3:0] code;
    input z;
    input n;
    input c;
    input v;
    input tc;
    input branch_input_pin;
    begin
        case (code)
            4'h0: test_code_field_true = ~z;
            4'h1: test_code_field_true = z;
            4'h2: test_code_field_true = ~z & ~n;
            4'h3: test_code_field_true = ~n;
            4'h4: test_code_field_true = n;
            4'h5: test_code_field_true = z | n;
            4'h6: test_code_field_true = c & ~z;
            4'h7: test_code_field_true = c;
            4'h8: test_code_field_true = ~c;
            4'h9: test_code_field_true = ~c | z;
            4'ha: test_code_field_true = ~v;
            4'hb: test_code_field_true = v;
            4'hc: test_code_field_true = ~tc;
            4'hd: test_code_field_true = tc;
            4'he: test_code_field_true = ~branch_input_pin;
            default: test_code_field_true = 1'b1;
        endcase
    end
endfunction

// Pick one low half out of the packed set
function [15:0] aux_pick;
    input [127:0] all;
    input [2:0] sel;
    begin
        aux_pick = all[sel*16 +: 16];
    end
endfunction

// Masked opcode compare
function op_match;
    input [15:0] word;
    input [15:0] mask;
    input [15:0] code;
    begin
        op_match = (word & mask) == code;
    end
endfunction

// Signed offset widened to the program counter
function [21:0] sext22;
    input [15:0] ofs;
    begin
        sext22 = {{6{ofs[15]}}, ofs};
    end
endfunction

// Program counter sum, wrapping at 22 bits
function [21:0] pc_add;
    input [21:0] base;
    input [21:0] delta;
    begin
        pc_add = base + delta;
    end
endfunction

// ----------------------------------------
// Decode
// ----------------------------------------
localparam ST_IDLE = 1'b0;
localparam ST_WAIT = 1'b1;

reg state_r;
reg [2:0] count_r;
reg obj_r;
reg map_r;

// Raw opcode classes, mode not yet applied
wire cmp_word = op_match(INSN_WORD, `BME_CMP_MASK, `BME_CMP_CODE);
wire qj_word = op_match(INSN_WORD, `BME_QJ_MASK, `BME_QJ_CODE);

// Accepted classes; compare and quick jump need object mode 1
wire is_loop = op_match(INSN_WORD, `BME_LOOP_MASK, `BME_LOOP_CODE);
wire is_cmp = cmp_word && obj_r;
wire is_qj = qj_word && obj_r;
wire is_map = INSN_WORD == `BME_MAP_CODE;
wire is_obj = INSN_WORD == `BME_OBJ_CODE;

// Legal words in the wrong mode, refused with a flag
wire mode1_only = (cmp_word || qj_word) && !obj_r;

// Register selects of the compare word
wire [2:0] sel_n = INSN_WORD[5:3];
wire [2:0] sel_m = INSN_WORD[2:0];

// Loop test value and compare outcome
wire [15:0] loop_val = aux_pick(AUX_LOW_ALL, INSN_WORD[2:0]);
wire loop_take = loop_val != 16'h0000;
wire cmp_eq = aux_pick(AUX_LOW_ALL, sel_n) == aux_pick(AUX_LOW_ALL, sel_m);
wire cmp_take = INSN_WORD[`BME_CMP_NE_BIT] ? !cmp_eq : cmp_eq;
// Flags arrive from the completed instruction before this one
wire qj_take = test_code_field_true(INSN_WORD[3:0], FLAG_Z, FLAG_N, FLAG_C, FLAG_V,
                         FLAG_TC, bio_sync_r);
wire qj_vtest = INSN_WORD[3:1] == 3'h5;


// Branch target and fall-through address
wire [21:0] off_ext = sext22(OFFSET_WORD);
wire [21:0] pc_take = pc_add(PC_IN, off_ext);
wire [21:0] pc_fall = pc_add(PC_IN, `BME_PC_STEP);

wire start = INSN_VALID && (state_r == ST_IDLE);
wire known = is_loop || is_cmp || is_qj || is_map || is_obj;

reg take_nxt;
reg [2:0] cyc_nxt;

// Outcome and cycle count of the accepted instruction
always @*
begin
    take_nxt = 1'b0;
    cyc_nxt = `BME_CYC_FALL;
    // Loop branch on a nonzero low half
    if (is_loop)
    begin
        take_nxt = loop_take;
        cyc_nxt = loop_take ? `BME_CYC_TAKEN : `BME_CYC_FALL;
    end
    // Register compare branch
    else if (is_cmp)
    begin
        take_nxt = cmp_take;
        cyc_nxt = cmp_take ? `BME_CYC_TAKEN : `BME_CYC_FALL;
    end
    // Flag-tested branch, fixed length
    else if (is_qj)
    begin
        take_nxt = qj_take;
        cyc_nxt = `BME_CYC_QUICK;
    end
    else if (is_map || is_obj)
    begin
        cyc_nxt = `BME_CYC_MODE;
    end
end

// ----------------------------------------
// Execution sequencer
// ----------------------------------------
// Results issue at acceptance, DONE marks the last cycle
always @(posedge CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        state_r <= ST_IDLE;
        count_r <= 3'h0;
        obj_r <= `BME_OBJ_RESET;
        map_r <= `BME_MAP_RESET;
        BUSY <= 1'b0;
        DONE <= 1'b0;
        BRANCH_TAKEN <= 1'b0;
        PC_NEXT <= 22'h000000;
        AUX_WE <= 1'b0;
        AUX_SEL <= 3'h0;
        AUX_WDATA <= 16'h0000;
        V_CLEAR <= 1'b0;
        RPT_CLEAR <= 1'b0;
        FLUSH <= 1'b0;
        ILLEGAL <= 1'b0;
    end
    else
    begin
        AUX_WE <= 1'b0;
        V_CLEAR <= 1'b0;
        RPT_CLEAR <= 1'b0;
        FLUSH <= 1'b0;
        ILLEGAL <= 1'b0;
        DONE <= 1'b0;
        BRANCH_TAKEN <= 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                if (start && known)
                begin
                    // Repeat prefix is dropped, instruction runs once
                    RPT_CLEAR <= RPT_PENDING;
                    BRANCH_TAKEN <= take_nxt;
                    PC_NEXT <= take_nxt ? pc_take : pc_fall;
                    // Post-decrement of the selected low half
                    if (is_loop)
                    begin
                        AUX_WE <= 1'b1;
                        AUX_SEL <= INSN_WORD[2:0];
                        AUX_WDATA <= loop_val - 16'h0001;
                    end
                    // Overflow test consumes the overflow flag
                    V_CLEAR <= is_qj && qj_vtest;
                    // Mode aliases clear their bit and flush
                    if (is_map)
                        map_r <= 1'b0;
                    if (is_obj)
                        obj_r <= 1'b0;
                    FLUSH <= is_map || is_obj;
                    // Remaining cycles after the accept edge
                    count_r <= cyc_nxt - 3'h1;
                    BUSY <= 1'b1;
                    state_r <= ST_WAIT;
                end
                else if (start && mode1_only)
                begin
                    // Refused: wrong object mode
                    ILLEGAL <= 1'b1;
                end
            end
            ST_WAIT:
            begin
                // Last cycle raises DONE and frees the sequencer
                if (count_r == 3'h1)
                begin
                    DONE <= 1'b1;
                    BUSY <= 1'b0;
                    state_r <= ST_IDLE;
                end
                count_r <= count_r - 3'h1;
            end
            default:
            begin
                // Unreachable codes fall back to idle
                state_r <= ST_IDLE;
            end
        endcase
    end
end

// ----------------------------------------
// Mode outputs and block placement
// ----------------------------------------
// Block one hit for the current fetch address
reg prog_hit_nxt;

// Low block hits block one only under legacy map
always @*
begin
    prog_hit_nxt = 1'b0;
    if (map_r)
        prog_hit_nxt = PROG_ADDR > `BME_BLK_TOP;
    else
        prog_hit_nxt = PROG_ADDR <= `BME_BLK_TOP;
end

// Mode bits shown to the rest of the core
always @(posedge CLK or negedge rst_n)
begin
    if (!rst_n)
    begin
        OBJECT_MODE <= `BME_OBJ_RESET;
        BLOCK_MAP <= `BME_MAP_RESET;
    end
    else
    begin
        OBJECT_MODE <= obj_r;
        BLOCK_MAP <= map_r;
    end
end

// Registered block lookup, one cycle behind the address
always @(posedge CLK or negedge rst_n)
begin
    if (!rst_n)
        PROG_HITS_ONE <= 1'b0;
    else
        PROG_HITS_ONE <= prog_hit_nxt;
end

endmodule
`default_nettype wire

// *** verification/bme_pmem.sv ***
`timescale 1ns/100ps
`default_nettype none
// Program memory presenting both words of one fetch
module bme_pmem
(
    input wire logic clk,
    input wire logic en,
    input wire logic [31:0] pair,
    output logic [15:0] insn,
    output logic [15:0] ofs
);
    logic [15:0] noise_r = 16'h0;
    // Changing pattern so stale words never look held
    always @(posedge clk)
        noise_r <= noise_r + 16'h3d07;
    assign insn = en ? pair[31:16] : ~noise_r;
    assign ofs = en ? pair[15:0] : noise_r;
endmodule
`default_nettype wire

// *** verification/bme_exec_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
// Port watcher for the branch and mode executor
module bme_chk
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic INSN_VALID,
    input wire logic [15:0] INSN_WORD,
    input wire logic [15:0] OFFSET_WORD,
    input wire logic [21:0] PC_IN,
    input wire logic RPT_PENDING,
    input wire logic [127:0] AUX_LOW_ALL,
    input wire logic [10:0] PROG_ADDR,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic BRANCH_TAKEN,
    input wire logic [21:0] PC_NEXT,
    input wire logic AUX_WE,
    input wire logic [2:0] AUX_SEL,
    input wire logic [15:0] AUX_WDATA,
    input wire logic RPT_CLEAR,
    input wire logic FLUSH,
    input wire logic ILLEGAL,
    input wire logic OBJECT_MODE,
    input wire logic BLOCK_MAP,
    input wire logic PROG_HITS_ONE
);
    logic [1:0] up_r;
    logic go;
    logic lw;
    logic [15:0] ax;
    // Edges since release; the core's own reset lags by two
    always_ff @(posedge CLK or negedge ARST_N)
        if (!ARST_N)
            up_r <= 2'h0;
        else if (up_r != 2'h3)
            up_r <= up_r + 2'h1;
    // Accepted request, loop word and its counter
    assign go = INSN_VALID && !BUSY;
    assign lw = go && (INSN_WORD & 16'hfff8) == 16'h0008;
    assign ax = AUX_LOW_ALL[INSN_WORD[2:0]*16 +: 16];
    default clocking @(posedge CLK);
    endclocking
    default disable iff (up_r != 2'h3);
    loop_sel_a:
        assert property (lw |=> AUX_WE && AUX_SEL == $past(INSN_WORD[2:0])
            && AUX_WDATA == $past(ax) - 16'h1) else $error("loop write wrong");
    loop_test_a:
        assert property (lw |=> BRANCH_TAKEN == ($past(ax) != 16'h0)) else $error("loop test");
    taken_pc_a:
        assert property (BRANCH_TAKEN |-> PC_NEXT == $past(PC_IN)
            + {{6{$past(OFFSET_WORD[15])}}, $past(OFFSET_WORD)}) else $error("target wrong");
    taken_len_a:
        assert property (BRANCH_TAKEN |-> !DONE ##1 !DONE ##1 !DONE ##1 DONE)
            else $error("taken length");
    fall_step_a:
        assert property (AUX_WE && !BRANCH_TAKEN |-> PC_NEXT == $past(PC_IN) + 22'h2
            ##1 DONE)
            else $error("fall through wrong");
    rpt_once_a:
        assert property (lw && RPT_PENDING |=> RPT_CLEAR ##1 !RPT_CLEAR && !AUX_WE)
            else $error("repeat not cleared");
    mode_refuse_a:
        assert property (go && !OBJECT_MODE && ((INSN_WORD & 16'hff80) == 16'h8f80
            || (INSN_WORD & 16'hfff0) == 16'h56c0) |=> ILLEGAL && !BUSY && !BRANCH_TAKEN)
            else $error("mode refusal wrong");
    mode_len_a:
        assert property (FLUSH |-> !DONE [*4] ##1 DONE) else $error("alias length");
    map_clear_a:
        assert property (go && INSN_WORD == 16'h563f |=> FLUSH ##4 !BLOCK_MAP)
            else $error("map bit not cleared");
    block_map_a:
        assert property ($stable(BLOCK_MAP) |-> PROG_HITS_ONE
            == ($past(PROG_ADDR[10]) == BLOCK_MAP)) else $error("block lookup wrong");
endmodule
bind bme_exec bme_chk chk_u (.*);
`default_nettype wire

// *** verification/tb_branch_and_mode_exec.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_branch_and_mode_exec;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic valid = 1'b0;
    logic repeat_prefix = 1'b0;
    logic [31:0] pair = 32'h0;
    logic [21:0] pc = 22'h0;
    logic [5:0] flg = 6'h15;
    logic [127:0] aux = 128'h0;
    logic [10:0] pa = 11'h0;
    logic [15:0] insn;
    logic [15:0] ofs;
    wire busy, done, tk, awe, ill, objm, bmap, hit, rclr, fl;
    wire [21:0] pcn;
    wire [15:0] awd;
    int mismatches = 0;
    int check_count = 0;
    always #2.5 clk = ~clk;
    bme_pmem pm_u (.clk(clk), .en(valid), .pair(pair), .insn(insn), .ofs(ofs));
    bme_exec dut_u (.CLK(clk), .ARST_N(arst_n), .INSN_VALID(valid), .INSN_WORD(insn),
        .OFFSET_WORD(ofs), .PC_IN(pc), .RPT_PENDING(repeat_prefix), .FLAG_Z(flg[0]), .FLAG_N(flg[1]),
        .FLAG_C(flg[2]), .FLAG_V(flg[3]), .FLAG_TC(flg[4]), .BIO_PIN(flg[5]),
        .AUX_LOW_ALL(aux), .PROG_ADDR(pa), .BUSY(busy), .DONE(done), .BRANCH_TAKEN(tk),
        .PC_NEXT(pcn), .AUX_WE(awe), .AUX_SEL(), .AUX_WDATA(awd), .V_CLEAR(),
        .RPT_CLEAR(rclr), .FLUSH(fl), .ILLEGAL(ill), .OBJECT_MODE(objm), .BLOCK_MAP(bmap),
        .PROG_HITS_ONE(hit));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One accepted instruction, timed from accept to completion
    task automatic exec(input logic [15:0] w, input logic [15:0] o, input logic [21:0] p,
        input logic [15:0] a, input logic r, input logic t, input int cyc);
        int n;
        logic [21:0] ex;
        ex = t ? p + {{6{o[15]}}, o} : p + 22'h2;
        @(posedge clk);
        pair <= {w, o};
        pc <= p;
        aux[w[2:0]*16 +: 16] <= a;
        repeat_prefix <= r;
        valid <= 1'b1;
        @(posedge clk);
        valid <= 1'b0;
        repeat_prefix <= 1'b0;
        #1;
        chk({tk, rclr, fl, awe}, {t, r, cyc == 5, cyc != 5});
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 9);
        if (done !== 1'b1)
        begin
            mismatches++;
            end_sim;
        end
        chk(n, cyc - 1);
        if (cyc != 5)
        begin
            chk(pcn, ex);
            chk(awd, 16'(a - 16'h1));
        end
    endtask
    // Request that must not start, with or without the refusal flag
    task automatic refuse(input logic [15:0] w, input logic e);
        @(posedge clk);
        pair <= {w, 16'h0010};
        flg <= w[5:0];
        valid <= 1'b1;
        @(posedge clk);
        valid <= 1'b0;
        #1;
        chk({ill, busy, tk}, {e, 2'b00});
        @(posedge clk);
    endtask
    // Program address lookup against block placement
    task automatic blk(input logic [10:0] addr, input logic e);
        @(posedge clk);
        pa <= addr;
        repeat (2) @(posedge clk);
        #1;
        chk(hit, e);
    endtask
    task automatic t_loop;
        exec(16'h000b, 16'h0020, 22'h3ffff0, 16'h0001, 1'b0, 1'b1, 4);
        exec(16'h000d, 16'h8000, 22'h000100, 16'h0000, 1'b1, 1'b0, 2);
        exec(16'h000f, 16'hfffe, 22'h000200, 16'h8000, 1'b0, 1'b1, 4);
        exec(16'h0008, 16'h7fff, 22'h000300, 16'hffff, 1'b1, 1'b1, 4);
    endtask
    task automatic t_refuse;
        refuse(16'h8f9a, 1'b1);
        refuse(16'h8fd1, 1'b1);
        for (int c = 0; c < 16; c++)
            refuse({12'h56c, c[3:0]}, 1'b1);
        refuse(16'h1234, 1'b0);
    endtask
    task automatic t_modes;
        blk(11'h400, 1'b1);
        blk(11'h3ff, 1'b0);
        exec(16'h563f, 16'h0000, 22'h000400, 16'h0000, 1'b1, 1'b0, 5);
        chk(bmap, 1'b0);
        blk(11'h3ff, 1'b1);
        blk(11'h7ff, 1'b0);
        exec(16'h5636, 16'h0000, 22'h000500, 16'h0000, 1'b0, 1'b0, 5);
        chk(objm, 1'b0);
    endtask
    // Reset, then every scenario in turn
    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({objm, bmap, busy, done}, 4'b0100);
        t_loop;
        t_refuse;
        t_modes;
        end_sim;
    end
endmodule
`default_nettype wire
